// ### dv/gpcmd_handler_props.sv
// Port checker for the GPIO command handler.
// Assumes it is bound to every gpcmd_handler instance.
`timescale 1ns/1ns
`default_nettype none
module gpcmd_props (
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic [31:0] gpio_avail_in,
	input wire logic        tx_ready_in,
	input wire logic        rx_ready_out,
	input wire logic [7:0]  tx_byte_out,
	input wire logic        tx_valid_out,
	input wire logic        tx_last_out,
	input wire logic [31:0] gpio_dir_out,
	input wire logic [31:0] gpio_low_active_out,
	input wire logic [31:0] gpio_active_out,
	input wire logic [31:0] gpio_pin_level_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	chk_tx_hold: assert property (
		tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
		else $error("reply byte not held");
	chk_last_valid: assert property (
		tx_last_out |-> tx_valid_out) else $error("last without valid");
	chk_bad_single: assert property (
		$rose(tx_valid_out) |-> (tx_byte_out == 8'hFF) == tx_last_out)
		else $error("reply length wrong");
	chk_code_echo: assert property (
		$rose(tx_valid_out) |-> tx_byte_out inside {8'h10, 8'h11, 8'h12,
		8'h13, 8'h19, 8'h1A, 8'h1B, 8'hFF}) else $error("bad reply code");
	chk_quiet_rx: assert property (
		rx_ready_out |-> !tx_valid_out) else $error("reply while receiving");
	chk_ready_back: assert property (
		tx_valid_out && tx_ready_in && tx_last_out |-> ##[1:4] rx_ready_out)
		else $error("receiver not re-armed");
	chk_hold_reply: assert property (
		tx_valid_out |=> $stable(gpio_active_out) && $stable(gpio_low_active_out))
		else $error("state moved during reply");
	chk_avail_mask: assert property (
		$stable(gpio_avail_in) |=> ((gpio_active_out | gpio_low_active_out |
		gpio_dir_out) & ~gpio_avail_in) == 32'h0) else $error("non-GPIO bit set");
	chk_pin_level: assert property (
		gpio_pin_level_out == (gpio_active_out ^ gpio_low_active_out))
		else $error("pin level wrong");
	cover property ($rose(tx_valid_out) && tx_byte_out == 8'hFF);
	cover property ($rose(tx_valid_out) && tx_byte_out == 8'h1B);
	cover property (tx_valid_out && !tx_ready_in);
endmodule
bind gpcmd_handler gpcmd_props i_props (.clk_in, .reset_in, .gpio_avail_in,
	.tx_ready_in, .rx_ready_out, .tx_byte_out, .tx_valid_out, .tx_last_out,
	.gpio_dir_out, .gpio_low_active_out, .gpio_active_out, .gpio_pin_level_out);
`default_nettype wire

// ### dv/gpcmd_host.sv
// Host model: sends nine-byte commands and collects the reply.
// Assumes the handler byte handshake; idle data shows the inverted last byte.
`timescale 1ns/1ns
`default_nettype none
module gpcmd_host (
	input  wire logic       clk_in,
	input  wire logic       rx_ready_in,
	input  wire logic [7:0] tx_byte_in,
	input  wire logic       tx_valid_in,
	input  wire logic       tx_last_in,
	output logic      [7:0] rx_byte_out,
	output logic            rx_valid_out,
	output logic            tx_ready_out
);
	initial begin
		rx_byte_out = 8'h00;
		rx_valid_out = 1'b0;
		tx_ready_out = 1'b0;
	end
	task automatic xfer(input logic [71:0] cmd, input bit slow,
		output logic [39:0] rsp, output int n);
		int k;
		bit acc;
		bit fin;
		n = 0;
		fin = 0;
		rsp = 40'h0;
		for (k = 0; k < 200 && rx_ready_in !== 1'b1; k++)
			@(posedge clk_in) #1;
		if (rx_ready_in !== 1'b1) begin
			n = -1;
			return;
		end
		for (k = 0; k < 9; k++) begin
			rx_byte_out = cmd[8*k+:8];
			rx_valid_out = 1'b1;
			@(posedge clk_in) #1;
		end
		rx_valid_out = 1'b0;
		rx_byte_out = ~rx_byte_out;
		// A slow sink accepts every other cycle to exercise the hold.
		for (k = 0; k < 400 && !fin; k++) begin
			tx_ready_out = !slow || k[0];
			acc = tx_valid_in === 1'b1 && tx_ready_out;
			if (acc && n < 5)
				rsp[8*n+:8] = tx_byte_in;
			n += acc;
			fin = acc && tx_last_in === 1'b1;
			@(posedge clk_in) #1;
		end
		tx_ready_out = 1'b0;
		if (!fin)
			n = -1;
	endtask
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the GPIO command handler.
// Assumes the host model and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [31:0] gpio_avail_in = 32'h0000_0203;
	logic        rx_ready_out, tx_valid_out, tx_last_out, rx_valid_in;
	logic        tx_ready_in;
	logic [7:0]  tx_byte_out, rx_byte_in;
	logic [31:0] gpio_dir_out, gpio_low_active_out, gpio_active_out;
	logic [31:0] gpio_pin_level_out, dir, low, act;
	logic [7:0]  codes [10] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h19, 8'h1A,
		8'h1B, 8'h00, 8'h14, 8'hFF};
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          seed = 21;
	int          i;
	always #2 clk_in = ~clk_in;
	gpcmd_handler i_dut (.clk_in, .reset_in, .rx_byte_in, .rx_valid_in,
		.gpio_avail_in, .tx_ready_in, .rx_ready_out, .tx_byte_out,
		.tx_valid_out, .tx_last_out, .gpio_dir_out, .gpio_low_active_out,
		.gpio_active_out, .gpio_pin_level_out);
	gpcmd_host i_host (.clk_in, .rx_ready_in(rx_ready_out),
		.tx_byte_in(tx_byte_out), .tx_valid_in(tx_valid_out),
		.tx_last_in(tx_last_out), .rx_byte_out(rx_byte_in),
		.rx_valid_out(rx_valid_in), .tx_ready_out(tx_ready_in));
	////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cmp40(input string nm, input logic [39:0] e, s);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [31:0] upd(input logic [31:0] o, m, v);
		return ((o & ~(m & gpio_avail_in)) | (v & m)) & gpio_avail_in;
	endfunction
	task automatic run(input logic [7:0] c, input logic [31:0] m, v);
		logic [39:0] rsp;
		logic [31:0] e;
		bit          ok;
		int          n;
		case (c)
			8'h19: dir = upd(dir, m, v);
			8'h1A: low = upd(low, m, v);
			8'h1B: act = upd(act, m, v);
			default: ;
		endcase
		case (c)
			8'h10: e = gpio_avail_in;
			8'h11, 8'h19: e = dir;
			8'h12, 8'h1A: e = low;
			8'h13, 8'h1B: e = act;
			default: e = 32'h0;
		endcase
		ok = c inside {8'h10, 8'h11, 8'h12, 8'h13, 8'h19, 8'h1A, 8'h1B};
		i_host.xfer({v, m, c}, 1'($random(seed)), rsp, n);
		if (n < 0) begin
			n_mismatch++;
			end_sim;
		end
		cmp40("reply", ok ? {e, c} : 40'hFF, rsp);
		cmp40("length", ok ? 40'h5 : 40'h1, 40'(n));
		cmp40("states", {8'h0, act}, {8'h0, gpio_active_out});
		cmp40("levels", {8'h0, low}, {8'h0, gpio_low_active_out});
		cmp40("dirs", {8'h0, dir}, {8'h0, gpio_dir_out});
		cmp40("pins", {8'h0, act ^ low}, {8'h0, gpio_pin_level_out});
	endtask
	initial begin
		{dir, low, act} = 96'h0;
		repeat (2) @(posedge clk_in);
		#1 reset_in = 1'b0;
		run(8'h10, 32'h0, 32'h0);
		run(8'h1B, 32'h0000_0201, 32'h0000_0001);
		foreach (codes[i])
			run(codes[i], $random(seed), $random(seed));
		gpio_avail_in = gpio_avail_in | $random(seed);
		for (i = 0; i < 40; i++)
			run(codes[{$random(seed)} % 10], $random(seed), $random(seed));
		// Settings do not survive a reset, so the model clears too.
		reset_in = 1'b1;
		repeat (2) @(posedge clk_in);
		#1 reset_in = 1'b0;
		{dir, low, act} = 96'h0;
		run(8'h13, $random(seed), $random(seed));
		run(8'h12, $random(seed), $random(seed));
		end_sim;
	end
endmodule
`default_nettype wire

// ### hw/gpcmd_cfg.svh
// Constants for the GPIO command handler: command codes, lengths, resets.
// Assumes inclusion by bare name from the design files.
`ifndef GPCMD_CFG_SVH
`define GPCMD_CFG_SVH
`define GPCMD_CMD_GET_FUNC   8'h10
`define GPCMD_CMD_GET_DIR    8'h11
`define GPCMD_CMD_GET_LEVEL  8'h12
`define GPCMD_CMD_GET_STATE  8'h13
`define GPCMD_CMD_SET_DIR    8'h19
`define GPCMD_CMD_SET_LEVEL  8'h1A
`define GPCMD_CMD_SET_STATE  8'h1B
`define GPCMD_BAD_CMD        8'hFF
`define GPCMD_CMD_LEN        4'h9
`define GPCMD_RSP_LEN        3'h5
`define GPCMD_RSP_BAD_LEN    3'h1
`define GPCMD_RST_VEC        32'h0000_0000
`endif

// ### hw/gpcmd_handler.sv
// GPIO control command handler: collects nine-byte commands, applies the
// masked set commands and returns the response bytes.
// Assumes a byte stream from the transport and one command in flight.
`timescale 1ns/1ns
`default_nettype none
`include "gpcmd_cfg.svh"
// How it works
// - Level mask picks which polarities change.
// - Level value one means active low.
// - Level reply carries resulting polarities.
// - State mask picks which states change.
// - State value one means active.
// - State reply echoes code plus states.
// - Masked-out state bits are ignored.
// - Get functions ignores its eight bytes.
// - Special-function pins report as unavailable.
// - Byte zero echoes the command code.
// - Commands are nine bytes, little endian.
// - Valid reply five bytes, else FFh.
// - Decode 10h-13h reads, 19h-1Bh sets.
module gpcmd_handler (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic [7:0]  rx_byte_in,
	input  wire logic        rx_valid_in,
	input  wire logic [31:0] gpio_avail_in,
	input  wire logic        tx_ready_in,
	output logic             rx_ready_out,
	output logic      [7:0]  tx_byte_out,
	output logic             tx_valid_out,
	output logic             tx_last_out,
	output logic      [31:0] gpio_dir_out,
	output logic      [31:0] gpio_low_active_out,
	output logic      [31:0] gpio_active_out,
	output logic      [31:0] gpio_pin_level_out
);
	////////////////////////////////////////////////////////////////////////
	gpcmd_pkg::gpcmd_state_t state_r;
	logic [71:0]             cmd_r;
	logic [3:0]              count_r;
	logic                    start_r;
	logic [39:0]             frame_r;
	logic [2:0]              len_r;
	logic                    exec_r;
	logic                    take;
	logic                    take_last;
	logic                    known;
	gpcmd_pkg::gpcmd_vec_t   rsp_vec;
	logic                    done;
	logic                    load_dir;
	logic                    load_level;
	logic                    load_state;
	logic [7:0]              code;
	gpcmd_pkg::gpcmd_vec_t   mask;
	gpcmd_pkg::gpcmd_vec_t   value;
	gpcmd_pkg::gpcmd_vec_t   dir_vec;
	gpcmd_pkg::gpcmd_vec_t   low_vec;
	gpcmd_pkg::gpcmd_vec_t   act_vec;
	gpcmd_pkg::gpcmd_vec_t   avail;

	// The mask is cut by availability here, so no masked register ever
	// changes a bit that belongs to a special-function pin.
	assign code  = cmd_r[7:0];
	assign mask  = cmd_r[39:8] & avail;
	assign value = cmd_r[71:40];
	assign avail = gpio_avail_in;

	// Only the three set commands write; gets and unknown codes leave
	// every setting alone.
	always_comb begin
		load_dir   = 1'b0;
		load_level = 1'b0;
		load_state = 1'b0;
		if (state_r == gpcmd_pkg::GPCMD_EXEC) begin
			case (code)
			`GPCMD_CMD_SET_DIR: begin
				load_dir = 1'b1;
			end
			`GPCMD_CMD_SET_LEVEL: begin
				load_level = 1'b1;
			end
			`GPCMD_CMD_SET_STATE: begin
				load_state = 1'b1;
			end
			default: begin
				load_dir = 1'b0;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive: bytes arrive low first; the host sends one command per reply,
	// so receive is simply closed while a command is executing or replying.
	assign take      = (state_r == gpcmd_pkg::GPCMD_RECV) && rx_valid_in;
	assign take_last = take && (count_r == `GPCMD_CMD_LEN - 4'h1);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cmd_r <= 72'h00_0000_0000_0000_0000;
		end else if (take) begin
			cmd_r <= {rx_byte_in, cmd_r[71:8]};
		end
	end

	// The count wraps on the ninth byte, so the next command starts at
	// byte zero without a separate clear.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			count_r <= 4'h0;
		end else if (take_last) begin
			count_r <= 4'h0;
		end else if (take) begin
			count_r <= count_r + 4'h1;
		end
	end

	// Ready drops at the edge that takes the ninth byte, so a host that
	// runs ahead is held off while the command runs.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rx_ready_out <= 1'b0;
		end else begin
			rx_ready_out <= (state_r == gpcmd_pkg::GPCMD_RECV)
				&& !take_last;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// SEND has no time limit of its own: a sink that never takes the last
	// byte holds the handler there until reset.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_r <= gpcmd_pkg::GPCMD_RECV;
		end else begin
			case (state_r)
			gpcmd_pkg::GPCMD_RECV: begin
				if (take_last) begin
					state_r <= gpcmd_pkg::GPCMD_EXEC;
				end
			end
			gpcmd_pkg::GPCMD_EXEC: begin
				state_r <= gpcmd_pkg::GPCMD_SEND;
			end
			gpcmd_pkg::GPCMD_SEND: begin
				if (done) begin
					state_r <= gpcmd_pkg::GPCMD_RECV;
				end
			end
			default: begin
				state_r <= gpcmd_pkg::GPCMD_RECV;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The pin vectors update in EXEC, so the reply built one cycle later
	// already shows the resulting values.
	gpcmd_masked_reg u_dir (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.load_in  (load_dir),
		.mask_in  (mask),
		.value_in (value),
		.vec_out  (dir_vec)
	);

	gpcmd_masked_reg u_level (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.load_in  (load_level),
		.mask_in  (mask),
		.value_in (value),
		.vec_out  (low_vec)
	);

	gpcmd_masked_reg u_state (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.load_in  (load_state),
		.mask_in  (mask),
		.value_in (value),
		.vec_out  (act_vec)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs pass through flops, each cut by the present availability, so
	// a pin handed to a special function reads as zero.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			gpio_dir_out <= `GPCMD_RST_VEC;
		end else begin
			gpio_dir_out <= dir_vec & avail;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			gpio_low_active_out <= `GPCMD_RST_VEC;
		end else begin
			gpio_low_active_out <= low_vec & avail;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			gpio_active_out <= `GPCMD_RST_VEC;
		end else begin
			gpio_active_out <= act_vec & avail;
		end
	end

	// Pin level is formed from the vectors, not from the other outputs, so
	// all four outputs change in the same cycle.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			gpio_pin_level_out <= `GPCMD_RST_VEC;
		end else begin
			gpio_pin_level_out <= (act_vec ^ low_vec) & avail;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reply. The frame is taken from the vectors one cycle after EXEC, once
	// the masked registers hold the new settings; a frame built in the same
	// edge as the load would echo the values from before the command.
	// The cost is one more cycle of reply latency.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			exec_r <= 1'b0;
		end else begin
			exec_r <= (state_r == gpcmd_pkg::GPCMD_EXEC);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			start_r <= 1'b0;
		end else begin
			start_r <= exec_r;
		end
	end

	// Get functions never looks at its parameters.
	always_comb begin
		known   = 1'b1;
		rsp_vec = 32'h0000_0000;
		case (code)
		`GPCMD_CMD_GET_FUNC: begin
			rsp_vec = avail;
		end
		`GPCMD_CMD_GET_DIR, `GPCMD_CMD_SET_DIR: begin
			rsp_vec = dir_vec & avail;
		end
		`GPCMD_CMD_GET_LEVEL, `GPCMD_CMD_SET_LEVEL: begin
			rsp_vec = low_vec & avail;
		end
		`GPCMD_CMD_GET_STATE, `GPCMD_CMD_SET_STATE: begin
			rsp_vec = act_vec & avail;
		end
		default: begin
			known = 1'b0;
		end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			frame_r <= 40'h00_0000_0000;
		end else if (known) begin
			frame_r <= {rsp_vec, code};
		end else begin
			frame_r <= {32'h0000_0000, `GPCMD_BAD_CMD};
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			len_r <= `GPCMD_RSP_BAD_LEN;
		end else if (known) begin
			len_r <= `GPCMD_RSP_LEN;
		end else begin
			len_r <= `GPCMD_RSP_BAD_LEN;
		end
	end

	// Low byte first puts the echoed code in byte zero and sends each
	// vector little endian.
	gpcmd_rsp_ser u_ser (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.start_in  (start_r),
		.frame_in  (frame_r),
		.len_in    (len_r),
		.ready_in  (tx_ready_in),
		.byte_out  (tx_byte_out),
		.valid_out (tx_valid_out),
		.last_out  (tx_last_out),
		.done_out  (done)
	);
endmodule
`default_nettype wire

// ### hw/gpcmd_masked_reg.sv
// One masked-update pin vector register.
// Assumes the caller qualifies the mask with the GPIO availability vector.
`timescale 1ns/1ns
`default_nettype none
`include "gpcmd_cfg.svh"
module gpcmd_masked_reg (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        load_in,
	input  wire logic [31:0] mask_in,
	input  wire logic [31:0] value_in,
	output logic      [31:0] vec_out
);
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			vec_out <= `GPCMD_RST_VEC;
		end else if (load_in) begin
			vec_out <= (vec_out & ~mask_in) | (value_in & mask_in);
		end
	end
endmodule
`default_nettype wire

// ### hw/gpcmd_pkg.sv
// Types shared by the GPIO command handler files.
// Assumes gpcmd_cfg.svh is on the include path.
`default_nettype none
package gpcmd_pkg;
	typedef logic [31:0] gpcmd_vec_t;
	typedef enum logic [2:0] {
		GPCMD_RECV = 3'b001,
		GPCMD_EXEC = 3'b010,
		GPCMD_SEND = 3'b100
	} gpcmd_state_t;
endpackage
`default_nettype wire

// ### hw/gpcmd_rsp_ser.sv
// Response byte serializer: sends up to five bytes, low byte first.
// Assumes the sink accepts a byte on any cycle where ready is high.
`timescale 1ns/1ns
`default_nettype none
`include "gpcmd_cfg.svh"
module gpcmd_rsp_ser (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        start_in,
	input  wire logic [39:0] frame_in,
	input  wire logic [2:0]  len_in,
	input  wire logic        ready_in,
	output logic      [7:0]  byte_out,
	output logic             valid_out,
	output logic             last_out,
	output logic             done_out
);
	logic [39:0] shift_r;
	logic [2:0]  left_r;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			shift_r   <= 40'h00_0000_0000;
			left_r    <= 3'h0;
			byte_out  <= 8'h00;
			valid_out <= 1'b0;
			last_out  <= 1'b0;
			done_out  <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				byte_out  <= frame_in[7:0];
				shift_r   <= {8'h00, frame_in[39:8]};
				left_r    <= len_in - 3'h1;
				valid_out <= 1'b1;
				last_out  <= (len_in == 3'h1);
			end else if (valid_out && ready_in) begin
				if (left_r == 3'h0) begin
					valid_out <= 1'b0;
					last_out  <= 1'b0;
					done_out  <= 1'b1;
				end else begin
					byte_out <= shift_r[7:0];
					shift_r  <= {8'h00, shift_r[39:8]};
					left_r   <= left_r - 3'h1;
					last_out <= (left_r == 3'h1);
				end
			end
		end
	end
endmodule
`default_nettype wire
